// ---- rtl/pts_pkg_events.sv ----
// package and per-channel interrupt event generator of the pwm timer
`timescale 1ns/1ps
package pts_pkg;
    localparam int PTS_NUM_CH = 4;
    localparam int PTS_CNT_W = 32;
    localparam int PTS_NUM_CMP = 6;
    localparam int PTS_NUM_EVT = 9;
    // event positions in the per-channel event vector
    localparam int PTS_EVT_A = 0;
    localparam int PTS_EVT_B = 1;
    localparam int PTS_EVT_C = 2;
    localparam int PTS_EVT_D = 3;
    localparam int PTS_EVT_E = 4;
    localparam int PTS_EVT_F = 5;
    localparam int PTS_EVT_OVF = 6;
    localparam int PTS_EVT_UDF = 7;
    localparam int PTS_EVT_PCS = 8;
    localparam logic [PTS_NUM_EVT-1:0] PTS_EVT_RST = 9'h000;
    // bit positions of the update and select registers
    localparam int PTS_UPD_W = 2;
    localparam int PTS_UPD_START = 0;
    localparam int PTS_UPD_STOP = 1;
    localparam logic [PTS_NUM_CH-1:0] PTS_RUN_RST = 4'h0;
    // channels in order 1, 2, 4, 5; period-count stop exists on 1, 4 and 5
    localparam logic [PTS_NUM_CH-1:0] PTS_PC_MASK = 4'hD;

    function automatic logic pts_hit(input logic [PTS_CNT_W-1:0] cnt,
                                     input logic [PTS_CNT_W-1:0] ref_val,
                                     input logic step);
        pts_hit = step && (cnt == ref_val);
    endfunction : pts_hit
endpackage : pts_pkg

module pts_chan_events #(
    parameter bit HAS_PC = 1'b1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // counter state
    input wire logic [pts_pkg::PTS_CNT_W-1:0] timer_count_value,
    input wire logic [pts_pkg::PTS_CNT_W-1:0] period_setting_register,
    input wire logic [pts_pkg::PTS_NUM_CMP-1:0][pts_pkg::PTS_CNT_W-1:0] compare_value,
    input wire logic count_step,
    input wire logic count_up,
    // capture and counter events
    input wire logic capture_a,
    input wire logic capture_b,
    input wire logic underflow_event,
    input wire logic period_count_stop_event,
    // event pulses
    output logic [pts_pkg::PTS_NUM_EVT-1:0] event_reg
);
    import pts_pkg::*;

    logic [PTS_NUM_EVT-1:0] event_next;

    always_comb begin
        event_next = PTS_EVT_RST;
        for (int i = 0; i < PTS_NUM_CMP; i++) begin
            event_next[i] = pts_hit(timer_count_value, compare_value[i], count_step);
        end
        event_next[PTS_EVT_A] = event_next[PTS_EVT_A] || capture_a;
        event_next[PTS_EVT_B] = event_next[PTS_EVT_B] || capture_b;
        event_next[PTS_EVT_OVF] = count_up &&
            pts_hit(timer_count_value, period_setting_register, count_step);
        event_next[PTS_EVT_UDF] = underflow_event;
        event_next[PTS_EVT_PCS] = HAS_PC && period_count_stop_event;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            event_reg <= PTS_EVT_RST;
        end else begin
            event_reg <= event_next;
        end
    end
endmodule : pts_chan_events

// ---- rtl/pts_top.sv ----
// pwm timer interrupt events and simultaneous operation-enable update
//
// Notes on behaviour
// - channels 1, 4 and 5 offer nine events: compares a-f, overflow, underflow, period-count stop; channel 2 offers the first eight.
// - compare a and b events fire on compare match and on input capture.
// - overflow event fires when the up-counting counter matches the period setting.
// - period-count stop event exists only on channels 1, 4 and 5.
// - every event can start a transfer-controller transfer.
// - writing 1 updates the enable of every channel selecting that bit.
// - non-secure writes to a secure channel's update register are ignored.
// - non-secure writes never change the enable of a secure channel.
`timescale 1ns/1ps
module pts_top #(
    parameter int NCH = pts_pkg::PTS_NUM_CH,
    parameter logic [pts_pkg::PTS_NUM_CH-1:0] PC_MASK = pts_pkg::PTS_PC_MASK
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // counter state per channel
    input wire logic [NCH-1:0][pts_pkg::PTS_CNT_W-1:0] timer_count_value,
    input wire logic [NCH-1:0][pts_pkg::PTS_CNT_W-1:0] period_setting_register,
    input wire logic [NCH-1:0][pts_pkg::PTS_NUM_CMP-1:0][pts_pkg::PTS_CNT_W-1:0] compare_value,
    input wire logic [NCH-1:0] count_step,
    input wire logic [NCH-1:0] count_up,
    // capture and counter events per channel
    input wire logic [NCH-1:0] capture_a,
    input wire logic [NCH-1:0] capture_b,
    input wire logic [NCH-1:0] underflow_event,
    input wire logic [NCH-1:0] period_count_stop_event,
    // write to a channel's simultaneous enable update register
    input wire logic update_write_valid,
    input wire logic [$clog2(NCH)-1:0] update_write_channel,
    input wire logic [pts_pkg::PTS_UPD_W-1:0] update_write_data,
    input wire logic update_write_nonsecure,
    // per-channel select and security attribute
    input wire logic [NCH-1:0][pts_pkg::PTS_UPD_W-1:0] simultaneous_enable_select_register,
    input wire logic [NCH-1:0] channel_secure,
    // interrupt events
    output logic [NCH-1:0] irq_match_capture_a,
    output logic [NCH-1:0] irq_match_capture_b,
    output logic [NCH-1:0] irq_match_c,
    output logic [NCH-1:0] irq_match_d,
    output logic [NCH-1:0] irq_match_e,
    output logic [NCH-1:0] irq_match_f,
    output logic [NCH-1:0] irq_overflow,
    output logic [NCH-1:0] irq_underflow,
    output logic [NCH-1:0] irq_period_count_stop,
    // transfer-controller start requests
    output logic [NCH-1:0][pts_pkg::PTS_NUM_EVT-1:0] transfer_controllers_trigger,
    // operation enable per channel
    output logic [NCH-1:0] operation_enable
);
    import pts_pkg::*;

    logic [NCH-1:0][PTS_NUM_EVT-1:0] event_bus;
    logic [NCH-1:0] run_reg;
    logic [NCH-1:0] run_next;
    logic write_ok;

    // interrupt events, one generator per channel
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        pts_chan_events #(
            .HAS_PC(PC_MASK[c])
        ) u_events (
            .clk_sys(clk_sys),
            .rst(rst),
            .timer_count_value(timer_count_value[c]),
            .period_setting_register(period_setting_register[c]),
            .compare_value(compare_value[c]),
            .count_step(count_step[c]),
            .count_up(count_up[c]),
            .capture_a(capture_a[c]),
            .capture_b(capture_b[c]),
            .underflow_event(underflow_event[c]),
            .period_count_stop_event(period_count_stop_event[c]),
            .event_reg(event_bus[c])
        );
        assign irq_match_capture_a[c] = event_bus[c][PTS_EVT_A];
        assign irq_match_capture_b[c] = event_bus[c][PTS_EVT_B];
        assign irq_match_c[c] = event_bus[c][PTS_EVT_C];
        assign irq_match_d[c] = event_bus[c][PTS_EVT_D];
        assign irq_match_e[c] = event_bus[c][PTS_EVT_E];
        assign irq_match_f[c] = event_bus[c][PTS_EVT_F];
        assign irq_overflow[c] = event_bus[c][PTS_EVT_OVF];
        assign irq_underflow[c] = event_bus[c][PTS_EVT_UDF];
        assign irq_period_count_stop[c] = event_bus[c][PTS_EVT_PCS];
        // every event source doubles as a transfer start
        assign transfer_controllers_trigger[c] = event_bus[c];
    end

    // simultaneous enable update
    // a non-secure write aimed at a secure channel's register is dropped whole
    assign write_ok = update_write_valid &&
        !(update_write_nonsecure && channel_secure[update_write_channel]);

    always_comb begin
        run_next = run_reg;
        if (write_ok) begin
            for (int c = 0; c < NCH; c++) begin
                // secure channels are out of reach of non-secure writes
                if (!(update_write_nonsecure && channel_secure[c])) begin
                    // zero bits leave enables alone; stop wins over start
                    if (update_write_data[PTS_UPD_STOP] &&
                        simultaneous_enable_select_register[c][PTS_UPD_STOP]) begin
                        run_next[c] = 1'b0;
                    end else if (update_write_data[PTS_UPD_START] &&
                        simultaneous_enable_select_register[c][PTS_UPD_START]) begin
                        run_next[c] = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_reg <= PTS_RUN_RST;
        end else begin
            run_reg <= run_next;
        end
    end

    assign operation_enable = run_reg;

    // assertions on the enable update and the event outputs
    sequence s_start_write(int c);
        update_write_valid && !update_write_nonsecure &&
        update_write_data[PTS_UPD_START] && !update_write_data[PTS_UPD_STOP] &&
        simultaneous_enable_select_register[c][PTS_UPD_START];
    endsequence

    sequence s_stop_write(int c);
        update_write_valid && !update_write_nonsecure &&
        update_write_data[PTS_UPD_STOP] &&
        simultaneous_enable_select_register[c][PTS_UPD_STOP];
    endsequence

    for (genvar c = 0; c < NCH; c++) begin : g_chk
        property p_start_sets(int k);
            @(posedge clk_sys) disable iff (rst)
            s_start_write(k) |=> operation_enable[k];
        endproperty
        a_start_sets: assert property (p_start_sets(c))
            else $error("selected channel not enabled by start write");

        property p_stop_clears(int k);
            @(posedge clk_sys) disable iff (rst)
            s_stop_write(k) |=> !operation_enable[k];
        endproperty
        a_stop_clears: assert property (p_stop_clears(c))
            else $error("selected channel not stopped by stop write");

        property p_secure_kept;
            @(posedge clk_sys) disable iff (rst)
            (update_write_valid && update_write_nonsecure && channel_secure[c])
                |=> $stable(operation_enable[c]);
        endproperty
        a_secure_kept: assert property (p_secure_kept)
            else $error("non-secure write changed a secure channel enable");

        property p_overflow_on_period;
            @(posedge clk_sys) disable iff (rst)
            (count_step[c] && count_up[c] &&
                timer_count_value[c] == period_setting_register[c]) |=> irq_overflow[c];
        endproperty
        a_overflow_on_period: assert property (p_overflow_on_period)
            else $error("overflow event missing at period match");

        property p_overflow_cause;
            @(posedge clk_sys) disable iff (rst)
            irq_overflow[c] |-> $past(count_step[c] && count_up[c]);
        endproperty
        a_overflow_cause: assert property (p_overflow_cause)
            else $error("overflow event without an up-count step");

        property p_capture_events;
            @(posedge clk_sys) disable iff (rst)
            (capture_a[c] || capture_b[c]) |=>
                (irq_match_capture_a[c] || !$past(capture_a[c])) &&
                (irq_match_capture_b[c] || !$past(capture_b[c]));
        endproperty
        a_capture_events: assert property (p_capture_events)
            else $error("capture did not raise its compare event");

        property p_pc_absent;
            @(posedge clk_sys) disable iff (rst)
            !PC_MASK[c] |-> !irq_period_count_stop[c];
        endproperty
        a_pc_absent: assert property (p_pc_absent)
            else $error("period-count stop event on a channel without it");

        property p_pc_present;
            @(posedge clk_sys) disable iff (rst)
            (PC_MASK[c] && period_count_stop_event[c]) |=> irq_period_count_stop[c];
        endproperty
        a_pc_present: assert property (p_pc_present)
            else $error("period-count stop event lost");

        property p_underflow_event;
            @(posedge clk_sys) disable iff (rst)
            underflow_event[c] |=> irq_underflow[c] && transfer_controllers_trigger[c][PTS_EVT_UDF];
        endproperty
        a_underflow_event: assert property (p_underflow_event)
            else $error("underflow event or its transfer trigger missing");
    end

    property p_nonsecure_target_ignored;
        @(posedge clk_sys) disable iff (rst)
        (update_write_valid && update_write_nonsecure &&
            channel_secure[update_write_channel]) |=> $stable(operation_enable);
    endproperty
    a_nonsecure_target_ignored: assert property (p_nonsecure_target_ignored)
        else $error("write to secure register by non-secure access took effect");

    property p_zero_write_no_effect;
        @(posedge clk_sys) disable iff (rst)
        (update_write_valid && update_write_data == '0) |=> $stable(operation_enable);
    endproperty
    a_zero_write_no_effect: assert property (p_zero_write_no_effect)
        else $error("zero write changed an operation enable");
endmodule : pts_top

// ---- test/pts_top_bench.sv ----
// self-checking bench for the pwm timer events and simultaneous enable update
`timescale 1ns/1ps
module pts_top_bench;
    import pts_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0][PTS_CNT_W-1:0] cnt_val, per_val;
    logic [3:0][PTS_NUM_CMP-1:0][PTS_CNT_W-1:0] cmp_val;
    logic [3:0] step, up, cap_a, cap_b, udf_in, pcs_in, sec, run_en, en_exp;
    logic [3:0] ev_a, ev_b, ev_c, ev_d, ev_e, ev_f, ev_ovf, ev_udf, ev_pcs;
    logic [3:0][PTS_NUM_EVT-1:0] trig;
    logic [3:0][1:0] sel;
    logic [1:0] wr_ch, wr_data;
    logic wr_valid, wr_ns;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    pts_top DUT (.clk_sys(clk_sys), .rst(rst), .timer_count_value(cnt_val),
        .period_setting_register(per_val), .compare_value(cmp_val), .count_step(step),
        .count_up(up), .capture_a(cap_a), .capture_b(cap_b), .underflow_event(udf_in),
        .period_count_stop_event(pcs_in), .update_write_valid(wr_valid),
        .update_write_channel(wr_ch), .update_write_data(wr_data),
        .update_write_nonsecure(wr_ns), .simultaneous_enable_select_register(sel),
        .channel_secure(sec), .irq_match_capture_a(ev_a), .irq_match_capture_b(ev_b),
        .irq_match_c(ev_c), .irq_match_d(ev_d), .irq_match_e(ev_e), .irq_match_f(ev_f),
        .irq_overflow(ev_ovf), .irq_underflow(ev_udf), .irq_period_count_stop(ev_pcs),
        .transfer_controllers_trigger(trig), .operation_enable(run_en));

    always #2 clk_sys = ~clk_sys;

    // hang guard, far above the roughly 160 cycles the tests need
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            $display("ERROR at %0t: timeout", $time);
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [8:0] ev_of(input int c);
        return {ev_pcs[c], ev_udf[c], ev_ovf[c], ev_f[c], ev_e[c], ev_d[c], ev_c[c],
                ev_b[c], ev_a[c]};
    endfunction : ev_of

    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic check_all(input int ch, input logic [8:0] exp);
        for (int c = 0; c < 4; c++) begin
            check(ev_of(c), (c == ch) ? exp : 9'h000, "event vector");
            check(trig[c], (c == ch) ? exp : 9'h000, "transfer trigger");
        end
    endtask : check_all

    // kinds 0-5 compare a-f, 6 overflow, 7 underflow, 8 stop, 9/10 capture a/b, 11 down
    task automatic fire(input int ch, input int kind);
        logic [8:0] exp;
        case (kind)
            8: exp = PTS_PC_MASK[ch] ? 9'h100 : 9'h000;
            9: exp = 9'h001;
            10: exp = 9'h002;
            11: exp = 9'h000;
            default: exp = 9'h001 << kind;
        endcase
        @(posedge clk_sys);
        if (kind < 6) begin
            cmp_val[ch][kind] <= 32'h0000_0010 + 32'(kind);
            cnt_val[ch] <= 32'h0000_0010 + 32'(kind);
            step[ch] <= 1'b1;
        end else if (kind == 6 || kind == 11) begin
            per_val[ch] <= 32'h0000_0020;
            cnt_val[ch] <= 32'h0000_0020;
            step[ch] <= 1'b1;
            up[ch] <= (kind == 6);
        end else if (kind == 7) begin
            udf_in[ch] <= 1'b1;
        end else if (kind == 8) begin
            pcs_in[ch] <= 1'b1;
        end else if (kind == 9) begin
            cap_a[ch] <= 1'b1;
        end else begin
            cap_b[ch] <= 1'b1;
        end
        @(posedge clk_sys);
        step <= 4'h0;
        up <= 4'h0;
        cap_a <= 4'h0;
        cap_b <= 4'h0;
        udf_in <= 4'h0;
        pcs_in <= 4'h0;
        #1 check_all(ch, exp);
        @(posedge clk_sys);
        #1 check_all(ch, 9'h000);
    endtask : fire

    task automatic upd(input logic [1:0] ch, input logic [1:0] data, input logic ns);
        @(posedge clk_sys);
        wr_valid <= 1'b1;
        wr_ch <= ch;
        wr_data <= data;
        wr_ns <= ns;
        for (int c = 0; c < 4; c++) begin
            if (!(ns && (sec[c] || sec[ch]))) begin
                if (data[PTS_UPD_STOP] && sel[c][PTS_UPD_STOP]) begin
                    en_exp[c] = 1'b0;
                end else if (data[PTS_UPD_START] && sel[c][PTS_UPD_START]) begin
                    en_exp[c] = 1'b1;
                end
            end
        end
        @(posedge clk_sys);
        wr_valid <= 1'b0;
        #1 check({5'h00, run_en}, {5'h00, en_exp}, "operation enable");
    endtask : upd

    task automatic test_events;
        for (int ch = 0; ch < 4; ch++) begin
            for (int k = 0; k < 12; k++) begin
                fire(ch, k);
            end
        end
        $display("test events done");
    endtask : test_events

    task automatic test_update;
        upd(2'h0, 2'h1, 1'b0);
        upd(2'h2, 2'h2, 1'b1);
        upd(2'h1, 2'h2, 1'b1);
        upd(2'h1, 2'h1, 1'b1);
        upd(2'h0, 2'h0, 1'b0);
        upd(2'h3, 2'h3, 1'b0);
        $display("test update done");
    endtask : test_update

    initial begin
        cnt_val = '0;
        per_val = {4{32'hFFFF_FFFE}};
        cmp_val = {24{32'hFFFF_FFFF}};
        {step, up, cap_a, cap_b, udf_in, pcs_in} = 24'h00_0000;
        {wr_valid, wr_ns, wr_ch, wr_data} = 6'h00;
        sel = {2'h3, 2'h3, 2'h2, 2'h3};
        sec = 4'h4;
        en_exp = 4'h0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1 check_all(-1, 9'h000);
        check({5'h00, run_en}, 9'h000, "enable after reset");
        test_events();
        test_update();
        report_and_stop();
    end
endmodule : pts_top_bench
